//--- core/acs_map.svh
// Purpose: register addresses, field positions and defaults of the auth control/status bank
// Assumes: 8-bit register port, bank in [9:8], location in [7:0] of a 10-bit address
// Notes: definitions only
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_ADDR_CFG 10'h000
`define ACS_ADDR_SET1 10'h002
`define ACS_ADDR_SET1_END 10'h005
`define ACS_ADDR_SET2 10'h006
`define ACS_ADDR_SET2_END 10'h009
`define ACS_ADDR_SET3 10'h00a
`define ACS_ADDR_SET3_END 10'h00d
`define ACS_ADDR_MCTL 10'h100
`define ACS_ADDR_STAT 10'h101
`define ACS_ADDR_SSEL 10'h200
`define ACS_ADDR_TRIM 10'h001
`define ACS_ADDR_ROM_END 10'h00f
`define ACS_SEL_COEF_HI 3
`define ACS_SEL_COEF_LO 2
`define ACS_SEL_SEED_HI 1
`define ACS_SEL_SEED_LO 0
`define ACS_CFG_DAB_HI 7
`define ACS_CFG_DAB_LO 6
`define ACS_CFG_GIE 3
`define ACS_CFG_AUTO_SLEEP_ENABLE 2
`define ACS_CFG_LOCK_HI 1
`define ACS_CFG_LOCK_LO 0
`define ACS_MC_ROMIE 7
`define ACS_MC_GIE 6
`define ACS_MC_AUTO_SLEEP_ENABLE 1
`define ACS_MC_SOFT_RESET_TRIGGER 0
`define ACS_ST_ROM 7
`define ACS_ST_BUS 6
`define ACS_ST_ACC 5
`define ACS_SEL_COEF_RST 2'h1
`define ACS_SEL_SEED_RST 2'h2
`define ACS_SEL_INVALID 2'h0
`define ACS_SLEEP_TIME_MS 1000
`define ACS_CLK_MHZ 100
`define ACS_BREAK_CYCLES 8'h40
`endif

//--- core/acs_pkg.sv
// Purpose: types shared by the auth control/status bank
// Assumes: included map header gives the numbers
// Notes: none
package acs_pkg;
	typedef logic [1:0] acs_sel_t;
	typedef enum logic [1:0] {ACS_RUN, ACS_SOFT_RESET_TRIGGER, ACS_BRK} acs_state_t;
endpackage

//--- core/acs_regs.sv
// Purpose: control, status and secret selection registers of the auth device
// Assumes: one-cycle rd/wr strobes from the bus framer; cfg word from rom is stable
// Notes: reads of status return flags then clear them
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_regs #(
	parameter int SLEEP_CYCLES = `ACS_SLEEP_TIME_MS * `ACS_CLK_MHZ * 1000
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [9:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [7:0] cfg_i,
	input wire logic cfg_ready_i,
	input wire logic rom_busy_i,
	input wire logic bad_pulse_i,
	input wire logic early_bus_i,
	input wire logic bad_count_i,
	input wire logic bad_auth_i,
	input wire logic test_mode_i,
	input wire logic bus_active_i,
	input wire logic sleep_cmd_i,
	input wire logic challenge_done_i,
	output logic response_valid_o,
	output acs_pkg::acs_sel_t coef_sel_o,
	output acs_pkg::acs_sel_t seed_sel_o,
	output logic reload_o,
	output logic secret_access_ok_o,
	output logic sleep_o,
	output logic irq_o,
	output logic break_o,
	output logic restart_o
);
	import acs_pkg::*;

	logic [7:0] cfg_r;
	logic cfg_loaded_r;
	logic gie_r;
	logic auto_sleep_enable_r;
	logic [2:0] flags_r;
	logic [2:0] flags_nxt;
	acs_sel_t coef_r;
	acs_sel_t seed_r;
	acs_state_t st_r;
	acs_state_t st_nxt;
	logic [7:0] brk_cnt_r;
	logic [31:0] idle_cnt_r;
	logic sleep_r;
	logic resp_r;
	logic reload_r;

	// address decode
	wire in_set12 = addr_i >= `ACS_ADDR_SET1 && addr_i <= `ACS_ADDR_SET2_END;
	wire in_set3 = addr_i >= `ACS_ADDR_SET3 && addr_i <= `ACS_ADDR_SET3_END;
	wire lock_hi = cfg_r[`ACS_CFG_LOCK_HI];
	wire lock_lo = cfg_r[`ACS_CFG_LOCK_LO];
	wire locked = lock_hi | lock_lo;
	wire secret_blk = (in_set12 & lock_hi) | (in_set3 & lock_lo);
	wire in_rom = addr_i <= `ACS_ADDR_ROM_END;
	wire in_test = addr_i == `ACS_ADDR_TRIM;
	wire acc = wr_i | rd_i;
	wire wr_mctl = wr_i && addr_i == `ACS_ADDR_MCTL && st_r == ACS_RUN;
	wire rd_stat = rd_i && addr_i == `ACS_ADDR_STAT;
	wire wr_ssel = wr_i && addr_i == `ACS_ADDR_SSEL;
	wire soft_reset_trigger_go = wr_mctl & wdata_i[`ACS_MC_SOFT_RESET_TRIGGER];
	wire sel_bad = coef_r == `ACS_SEL_INVALID || seed_r == `ACS_SEL_INVALID;
	wire romie = cfg_loaded_r & ~locked;
	wire locked_read = rd_i & secret_blk;

	// flag events
	wire ev_rom = acc & rom_busy_i;
	wire ev_bus = bad_pulse_i | early_bus_i | bad_count_i | bad_auth_i | locked_read
		| (challenge_done_i & sel_bad);
	wire ev_acc = (wr_i & in_rom & !in_test & locked) | (acc & in_test & ~test_mode_i);

	// read clear with set winning over clear
	always_comb begin
		flags_nxt = rd_stat ? 3'h0 : flags_r;
		if (ev_rom) flags_nxt[2] = 1'b1;
		if (ev_bus) flags_nxt[1] = 1'b1;
		if (ev_acc) flags_nxt[0] = 1'b1;
	end

	// soft reset sequencer
	always_comb begin
		case (st_r)
			ACS_RUN: st_nxt = soft_reset_trigger_go ? ACS_SOFT_RESET_TRIGGER : ACS_RUN;
			ACS_SOFT_RESET_TRIGGER: st_nxt = cfg_ready_i ? ACS_BRK : ACS_SOFT_RESET_TRIGGER;
			ACS_BRK: st_nxt = brk_cnt_r == 8'h01 ? ACS_RUN : ACS_BRK;
			default: st_nxt = ACS_RUN;
		endcase
	end

	// read mux
	wire [7:0] mctl_rd = {romie, gie_r, 4'h0, auto_sleep_enable_r, 1'b0};
	wire [7:0] stat_rd = {flags_r, 1'b0, cfg_r[`ACS_CFG_DAB_HI:`ACS_CFG_DAB_LO],
		cfg_r[`ACS_CFG_LOCK_HI:`ACS_CFG_LOCK_LO]};
	wire [7:0] ssel_rd = {4'h0, coef_r, seed_r};
	wire [7:0] rd_mux = addr_i == `ACS_ADDR_MCTL ? mctl_rd :
		addr_i == `ACS_ADDR_STAT ? stat_rd :
		addr_i == `ACS_ADDR_SSEL ? ssel_rd : 8'h00;

	// config capture, reloaded after power-up and soft reset
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_r <= 8'h00;
			cfg_loaded_r <= 1'b0;
		end else if (st_r == ACS_SOFT_RESET_TRIGGER) begin
			cfg_loaded_r <= 1'b0;
		end else if (!cfg_loaded_r && cfg_ready_i) begin
			cfg_r <= cfg_i;
			cfg_loaded_r <= 1'b1;
		end
	end

	// control bits
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			gie_r <= 1'b0;
			auto_sleep_enable_r <= 1'b0;
		end else if (!cfg_loaded_r && cfg_ready_i && st_r != ACS_SOFT_RESET_TRIGGER) begin
			gie_r <= cfg_i[`ACS_CFG_GIE];
			auto_sleep_enable_r <= cfg_i[`ACS_CFG_AUTO_SLEEP_ENABLE];
		end else if (wr_mctl) begin
			gie_r <= wdata_i[`ACS_MC_GIE];
			auto_sleep_enable_r <= wdata_i[`ACS_MC_AUTO_SLEEP_ENABLE];
		end
	end

	// flags, selection, sequencer
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flags_r <= 3'h0;
			coef_r <= `ACS_SEL_COEF_RST;
			seed_r <= `ACS_SEL_SEED_RST;
			st_r <= ACS_RUN;
			brk_cnt_r <= 8'h00;
			reload_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			reload_r <= wr_ssel;
			if (st_r == ACS_SOFT_RESET_TRIGGER) begin
				flags_r <= 3'h0;
				coef_r <= `ACS_SEL_COEF_RST;
				seed_r <= `ACS_SEL_SEED_RST;
				brk_cnt_r <= `ACS_BREAK_CYCLES;
			end else begin
				flags_r <= flags_nxt;
				if (brk_cnt_r != 8'h00) brk_cnt_r <= brk_cnt_r - 8'h01;
				if (wr_ssel) begin
					coef_r <= wdata_i[`ACS_SEL_COEF_HI:`ACS_SEL_COEF_LO];
					seed_r <= wdata_i[`ACS_SEL_SEED_HI:`ACS_SEL_SEED_LO];
				end
			end
		end
	end

	// inactivity timer and sleep
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			idle_cnt_r <= 32'h0;
			sleep_r <= 1'b0;
		end else if (st_r != ACS_RUN || bus_active_i || acc) begin
			idle_cnt_r <= 32'h0;
			sleep_r <= 1'b0;
		end else if (sleep_cmd_i) begin
			sleep_r <= 1'b1;
		end else if (auto_sleep_enable_r && idle_cnt_r >= SLEEP_CYCLES[31:0] - 32'h1) begin
			sleep_r <= 1'b1;
		end else if (!sleep_r) begin
			idle_cnt_r <= idle_cnt_r + 32'h1;
		end
	end

	// read data and response gate
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= 8'h00;
			resp_r <= 1'b0;
		end else begin
			if (rd_i) rdata_o <= secret_blk ? 8'h00 : rd_mux;
			resp_r <= challenge_done_i & ~sel_bad;
		end
	end

	assign coef_sel_o = coef_r;
	assign seed_sel_o = seed_r;
	assign reload_o = reload_r;
	assign response_valid_o = resp_r;
	assign secret_access_ok_o = ~secret_blk;
	assign sleep_o = sleep_r;
	assign irq_o = (romie & flags_r[2]) | (gie_r & (flags_r[1] | flags_r[0]));
	assign break_o = st_r == ACS_BRK;
	assign restart_o = st_r == ACS_SOFT_RESET_TRIGGER;

	// secret lock-out gating
	lock_block_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(lock_hi && in_set12) |-> !secret_access_ok_o)
		else $error("set12 not blocked");

	lock3_block_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(lock_lo && in_set3) |-> !secret_access_ok_o)
		else $error("set3 not blocked");

	// interrupt enables and gating
	romie_lock_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(cfg_loaded_r && locked) |-> !mctl_rd[7])
		else $error("rom irq enable not zero");

	rom_irq_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ev_rom && romie && !restart_o) |=> irq_o)
		else $error("rom busy irq missed");

	err_gate_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(!gie_r && !flags_r[2]) |-> !irq_o)
		else $error("irq leaks when disabled");

	cfg_load_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(!cfg_loaded_r && cfg_ready_i && !restart_o) |=> (gie_r == $past(cfg_i[`ACS_CFG_GIE])
		&& auto_sleep_enable_r == $past(cfg_i[`ACS_CFG_AUTO_SLEEP_ENABLE])))
		else $error("control defaults not loaded");

	// soft reset steps: request, reload wait, break, back to run
	sequence soft_reset_trigger_seq;
		soft_reset_trigger_go ##1 restart_o;
	endsequence

	sequence brk_last_seq;
		break_o && brk_cnt_r == 8'h01;
	endsequence

	soft_reset_trigger_read_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		mctl_rd[0] == 1'b0)
		else $error("soft reset bit reads one");

	soft_reset_trigger_default_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		restart_o |=> (coef_sel_o == `ACS_SEL_COEF_RST && seed_sel_o == `ACS_SEL_SEED_RST
		&& flags_r == 3'h0))
		else $error("soft reset defaults missing");

	break_after_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		soft_reset_trigger_seq ##0 cfg_ready_i |=> break_o)
		else $error("no break after reset");

	break_end_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		brk_last_seq |=> !break_o)
		else $error("break does not end");

	// status flags, set beats clear
	rom_flag_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ev_rom && !restart_o) |=> flags_r[2])
		else $error("rom busy flag missed");

	bus_err_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(bad_pulse_i && !restart_o) |=> flags_r[1])
		else $error("bus error missed");

	locked_read_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(locked_read && !restart_o) |=> (flags_r[1] && rdata_o == 8'h00))
		else $error("locked read not flagged");

	acc_flag_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ev_acc && !restart_o) |=> flags_r[0])
		else $error("access error missed");

	stat_clear_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(rd_stat && !ev_rom && !ev_bus && !ev_acc && !restart_o) |=> flags_r == 3'h0)
		else $error("status not cleared");

	// selection and response gate
	sel_write_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(wr_ssel && !restart_o) |=>
		coef_sel_o == $past(wdata_i[`ACS_SEL_COEF_HI:`ACS_SEL_COEF_LO]))
		else $error("coef select not written");

	seed_write_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(wr_ssel && !restart_o) |=>
		seed_sel_o == $past(wdata_i[`ACS_SEL_SEED_HI:`ACS_SEL_SEED_LO]))
		else $error("seed select not written");

	bad_sel_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(challenge_done_i && sel_bad) |=> !response_valid_o)
		else $error("bad sel response");

	good_sel_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(challenge_done_i && !sel_bad) |=> response_valid_o)
		else $error("good sel gave no response");

	// sleep entry
	sleep_cmd_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(sleep_cmd_i && st_r == ACS_RUN && !bus_active_i && !acc) |=> sleep_o)
		else $error("sleep command ignored");

	no_auto_sleep_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(!auto_sleep_enable_r && !sleep_cmd_i && !sleep_o) |=> !sleep_o)
		else $error("slept without auto sleep");
endmodule

//--- dv/acs_rom_model.sv
// Purpose: far-side model that feeds the config word out of rom
// Assumes: restart_i stays high while the bank wants a reload
// Notes: cfg lines show the inverted word while not ready
`timescale 1ns/1ps
module acs_rom_model (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic restart_i,
	input wire logic [7:0] word_i,
	output logic [7:0] cfg_o,
	output logic ready_o
);
	logic [2:0] wait_r;
	// load delay, restarted by every reload request
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wait_r <= 3'h0;
		end else begin
			wait_r <= restart_i ? 3'h0 : wait_r + {2'h0, wait_r != 3'h7};
		end
	end
	// word is stale-looking until ready; lower lock bit left clear by bench
	assign ready_o = (wait_r == 3'h7);
	assign cfg_o = ready_o ? word_i : ~word_i;
endmodule

//--- dv/test_acs_regs.sv
// Purpose: register-level checks of the auth control/status bank
// Assumes: sleep timer cut to 50 cycles
// Notes: bus faults come in as one-cycle event pulses
`timescale 1ns/1ps
`include "acs_map.svh"
module test_acs_regs;
	logic core_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [9:0] addr = 10'h0;
	logic [7:0] wdata = 8'h0, word = 8'hcc, rdata, cfg;
	logic wr = 0, rd = 0, busy = 0, tmode = 0, act = 0, chal = 0, scmd = 0;
	logic [3:0] ev = 4'h0;
	logic rdy, rv, aok, slp, irq, brk, pend, rld;
	logic [1:0] coef, seed;
	int n_fail = 0, samples_checked = 0, k;
	always #5 core_clk_i = ~core_clk_i;
	acs_rom_model u_acs_rom_model (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
		.restart_i(pend), .word_i(word), .cfg_o(cfg), .ready_o(rdy));
	acs_regs #(.SLEEP_CYCLES(50)) u_acs_regs (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.cfg_i(cfg), .cfg_ready_i(rdy), .rom_busy_i(busy), .bad_pulse_i(ev[0]),
		.early_bus_i(ev[1]), .bad_count_i(ev[2]), .bad_auth_i(ev[3]),
		.test_mode_i(tmode), .bus_active_i(act), .sleep_cmd_i(scmd),
		.challenge_done_i(chal), .response_valid_o(rv), .coef_sel_o(coef),
		.seed_sel_o(seed), .reload_o(rld), .secret_access_ok_o(aok), .sleep_o(slp),
		.irq_o(irq), .break_o(brk), .restart_o(pend));
	// verdict and end of run
	task automatic print_verdict();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wrt(input logic [9:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk_i);
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [9:0] a, input logic [7:0] e);
		@(posedge core_clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk_i);
		rd <= 1'b0;
		@(posedge core_clk_i);
		#1 chk("rdata", e, rdata);
	endtask
	task automatic evt(input logic [3:0] v);
		@(posedge core_clk_i);
		ev <= v;
		@(posedge core_clk_i);
		ev <= 4'h0;
	endtask
	task automatic chl(input logic e);
		@(posedge core_clk_i);
		chal <= 1'b1;
		@(posedge core_clk_i);
		chal <= 1'b0;
		#1 chk("resp", {7'h0, e}, {7'h0, rv});
	endtask
	// bounded wait for the break line to reach v
	task automatic wbrk(input logic v, output int n);
		n = 0;
		while (brk !== v) begin
			@(posedge core_clk_i);
			#1 n++;
			if (n > 300) begin
				n_fail++;
				print_verdict();
			end
		end
	endtask
	initial begin
		repeat (10) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		repeat (12) @(posedge core_clk_i);
		rdc(`ACS_ADDR_MCTL, 8'hc2);
		rdc(`ACS_ADDR_STAT, 8'h0c);
		rdc(`ACS_ADDR_SSEL, 8'h06);
		repeat (60) @(posedge core_clk_i);
		#1 chk("sleep", 8'h01, {7'h0, slp});
		@(posedge core_clk_i);
		act <= 1'b1;
		@(posedge core_clk_i);
		act <= 1'b0;
		#1 chk("sleep", 8'h00, {7'h0, slp});
		wrt(`ACS_ADDR_MCTL, 8'h40);
		rdc(`ACS_ADDR_MCTL, 8'hc0);
		repeat (60) @(posedge core_clk_i);
		#1 chk("sleep", 8'h00, {7'h0, slp});
		@(posedge core_clk_i);
		scmd <= 1'b1;
		@(posedge core_clk_i);
		scmd <= 1'b0;
		#1 chk("sleep", 8'h01, {7'h0, slp});
		for (int i = 0; i < 4; i++) begin
			evt(4'h1 << i);
			#1 chk("irq", 8'h01, {7'h0, irq});
			rdc(`ACS_ADDR_STAT, 8'h4c);
			rdc(`ACS_ADDR_STAT, 8'h0c);
		end
		wrt(`ACS_ADDR_MCTL, 8'h00);
		evt(4'h1);
		#1 chk("irq", 8'h00, {7'h0, irq});
		rdc(`ACS_ADDR_STAT, 8'h4c);
		@(posedge core_clk_i);
		busy <= 1'b1;
		rdc(`ACS_ADDR_SSEL, 8'h06);
		chk("irq", 8'h01, {7'h0, irq});
		@(posedge core_clk_i);
		busy <= 1'b0;
		rdc(`ACS_ADDR_STAT, 8'h8c);
		wrt(10'h001, 8'h55);
		rdc(`ACS_ADDR_STAT, 8'h2c);
		@(posedge core_clk_i);
		tmode <= 1'b1;
		wrt(10'h001, 8'h55);
		rdc(`ACS_ADDR_STAT, 8'h0c);
		@(posedge core_clk_i);
		tmode <= 1'b0;
		wrt(`ACS_ADDR_SSEL, 8'h00);
		chl(1'b0);
		rdc(`ACS_ADDR_STAT, 8'h4c);
		wrt(`ACS_ADDR_SSEL, 8'h0f);
		#1 chk("sel", 8'h0f, {4'h0, coef, seed});
		chk("reload", 8'h01, {7'h0, rld});
		chl(1'b1);
		@(posedge core_clk_i);
		word <= 8'hce;
		wrt(`ACS_ADDR_MCTL, 8'h01);
		wbrk(1'b1, k);
		wbrk(1'b0, k);
		chk("break", 8'h40, k[7:0]);
		rdc(`ACS_ADDR_MCTL, 8'h42);
		rdc(`ACS_ADDR_SSEL, 8'h06);
		rdc(`ACS_ADDR_SET1, 8'h00);
		rdc(`ACS_ADDR_STAT, 8'h4e);
		@(posedge core_clk_i);
		addr <= `ACS_ADDR_SET2;
		#1 chk("access", 8'h00, {7'h0, aok});
		@(posedge core_clk_i);
		addr <= `ACS_ADDR_SET3;
		#1 chk("access", 8'h01, {7'h0, aok});
		print_verdict();
	end
endmodule
